//--- core/vpc_capture.sv
// Purpose: Capture engine of an 8-bit video input port
// Assumes: Decoder bytes synchronous to clock, one per cycle
// Notes: Codes are FF 00 00 XY; XY bit 4 set marks end of line
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module vpc_capture
  import vpc_pkg::*;
#(
  parameter int LINE_WIDTH = 10
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] video_byte_bus,
  input wire logic fifo_ready,
  output vpc_pixel_type fifo_pixel,
  output logic active_video_flag,
  output logic bus_float,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);

  // Region count must fit the 16-bit register word
  if (LINE_WIDTH < 4 || LINE_WIDTH > 16) begin : g_bad_width
    $error("LINE_WIDTH out of range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ctrl_reg;
  logic [7:0] vbi_start_reg;
  logic [7:0] vbi_end_reg;
  logic [LINE_WIDTH-1:0] vbi_lines_reg;
  logic [15:0] count_reg;
  logic [15:0] rdata_reg;
  logic overflow_reg;

  wire capture_enable = ctrl_reg[VPC_CTRL_EN_BIT];
  wire [1:0] vbi_mode = ctrl_reg[VPC_CTRL_MODE_LSB +: 2];
  wire [4:0] scale_raw = ctrl_reg[VPC_CTRL_SCALE_LSB +: 5];
  // Zero scale would pass every line; treat as one
  wire [4:0] scale = (scale_raw == 5'h00) ? VPC_SCALE_MIN : scale_raw;

  // ----------------------------------------
  // Code detection
  // ----------------------------------------
  logic [7:0] b1_reg;
  logic [7:0] b2_reg;
  logic [7:0] b3_reg;
  wire preamble = (b3_reg == VPC_PRE_FF) && (b2_reg == VPC_PRE_00) && (b1_reg == VPC_PRE_00);
  wire code_byte = preamble;
  wire sav_seen = code_byte && vpc_is_sav(video_byte_bus);
  wire eav_seen = code_byte && vpc_is_eav(video_byte_bus);
  // Normal SAV: low bits pattern x00 (V low, H low); normal EAV: H high
  wire sav_active = sav_seen && !video_byte_bus[VPC_V_BIT];
  wire eav_line_end = eav_seen;
  wire field_bit = video_byte_bus[VPC_F_BIT];
  // FF byte could be start of a code; in a line window it is not stored
  wire pre_start = (video_byte_bus == VPC_PRE_FF);

  // ----------------------------------------
  // Capture state
  // ----------------------------------------
  vpc_state_type state_reg;
  vpc_state_type state_next;
  vpc_phase_type phase_reg;
  logic vbi_done_reg;
  logic vbi_armed_reg;
  logic last_field_reg;
  logic [4:0] line_div_reg;
  logic [LINE_WIDTH-1:0] vbi_line_cnt_reg;

  wire keep_line = (line_div_reg == 5'h00);
  wire vbi_sav_match = sav_seen && (video_byte_bus == vbi_start_reg);
  wire vbi_eav_match = eav_seen && (video_byte_bus == vbi_end_reg);
  wire field_change = code_byte && (field_bit != last_field_reg);
  wire vbi_region = (vbi_mode == VPC_VBI_RAW) && (vbi_line_cnt_reg != '0);
  // Blanking starts at the end code that flags the vertical interval
  wire raw_vbi_start = (vbi_mode == VPC_VBI_RAW) && !vbi_done_reg && eav_seen
                       && video_byte_bus[VPC_V_BIT] && vbi_region;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VPC_ST_IDLE: begin
        if (!capture_enable) begin
          state_next = VPC_ST_IDLE;
        end else if (raw_vbi_start) begin
          state_next = VPC_ST_VBI;
        end else if (vbi_mode == VPC_VBI_FRAMED && vbi_armed_reg && sav_seen) begin
          state_next = VPC_ST_LINE;
        end else if (vbi_mode == VPC_VBI_FRAMED && !vbi_done_reg && vbi_sav_match) begin
          state_next = VPC_ST_LINE;
        end else if (sav_active && keep_line) begin
          state_next = VPC_ST_LINE;
        end
      end
      VPC_ST_LINE: begin
        if (!capture_enable) begin
          state_next = VPC_ST_IDLE;
        end else if (raw_vbi_start) begin
          // Last active line hands over straight to raw blanking
          state_next = VPC_ST_VBI;
        end else if (eav_line_end) begin
          state_next = VPC_ST_IDLE;
        end
      end
      VPC_ST_VBI: begin
        // Raw blanking: every byte but code bytes stored until the next SAV
        if (!capture_enable) begin
          state_next = VPC_ST_IDLE;
        end else if (sav_active && keep_line) begin
          // Closing SAV may open an active line at once
          state_next = VPC_ST_LINE;
        end else if (sav_seen) begin
          state_next = VPC_ST_IDLE;
        end
      end
      default: begin
        state_next = VPC_ST_IDLE;
      end
    endcase
  end

  // Data byte is the current bus byte; preamble bytes are dropped in a line window only, raw blanking stores them
  wire in_window = (state_reg != VPC_ST_IDLE);
  wire store_now = in_window && !preamble && !pre_start
                   && !(b1_reg == VPC_PRE_FF) && !(b2_reg == VPC_PRE_FF && b1_reg == VPC_PRE_00);
  wire stored_byte_ok = in_window && !code_byte;
  wire take_byte = stored_byte_ok && !(state_reg == VPC_ST_LINE && !store_now);
  wire overflow_set = take_byte && !fifo_ready;
  wire overflow_clear = reg_write && (reg_addr == VPC_STATUS_ADDR) && reg_wdata[0];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      state_reg <= VPC_ST_IDLE;
      phase_reg <= VPC_PHASE_CB;
      vbi_done_reg <= 1'b0;
      vbi_armed_reg <= 1'b0;
      last_field_reg <= 1'b0;
      line_div_reg <= 5'h00;
      vbi_line_cnt_reg <= '0;
      fifo_pixel <= '0;
      count_reg <= 16'h0000;
      overflow_reg <= 1'b0;
    end else begin
      b1_reg <= video_byte_bus;
      b2_reg <= b1_reg;
      b3_reg <= b2_reg;
      state_reg <= state_next;
      fifo_pixel.valid <= 1'b0;
      if (take_byte) begin
        fifo_pixel.valid <= 1'b1;
        fifo_pixel.data <= video_byte_bus;
        fifo_pixel.phase <= phase_reg;
        count_reg <= count_reg + 16'h0001;
        if (!fifo_ready) begin
          overflow_reg <= 1'b1;
        end
      end
      // Cb, Y0, Cr, Y1, then back to Cb
      // Every window opening restarts the group at Cb
      if (state_reg == VPC_ST_IDLE || state_next != state_reg) begin
        phase_reg <= VPC_PHASE_CB;
      end else if (take_byte) begin
        case (phase_reg)
          VPC_PHASE_CB: phase_reg <= VPC_PHASE_Y0;
          VPC_PHASE_Y0: phase_reg <= VPC_PHASE_CR;
          VPC_PHASE_CR: phase_reg <= VPC_PHASE_Y1;
          default: phase_reg <= VPC_PHASE_CB;
        endcase
      end
      // Line decimation counts each active line start
      if (sav_active) begin
        line_div_reg <= (line_div_reg + 5'h01 >= scale) ? 5'h00 : line_div_reg + 5'h01;
      end
      if (code_byte) begin
        last_field_reg <= field_bit;
      end
      if (field_change) begin
        vbi_done_reg <= 1'b0;
        vbi_armed_reg <= 1'b0;
        line_div_reg <= 5'h00;
        vbi_line_cnt_reg <= vbi_lines_reg;
        count_reg <= 16'h0000;
      end else begin
        if (state_reg == VPC_ST_VBI && sav_seen) begin
          vbi_done_reg <= 1'b1;
        end
        if (vbi_mode == VPC_VBI_FRAMED && vbi_sav_match && !vbi_done_reg) begin
          vbi_armed_reg <= 1'b1;
        end
        if (vbi_mode == VPC_VBI_FRAMED && vbi_armed_reg && vbi_eav_match) begin
          vbi_armed_reg <= 1'b0;
          vbi_done_reg <= 1'b1;
        end
      end
      // Set wins over a clear in the same cycle
      if (overflow_clear && !overflow_set) begin
        overflow_reg <= 1'b0;
      end
    end
  end

  assign active_video_flag = fifo_pixel.valid;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= VPC_CTRL_RESET;
      vbi_start_reg <= 8'h00;
      vbi_end_reg <= 8'h00;
      vbi_lines_reg <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        VPC_CTRL_ADDR: ctrl_reg <= reg_wdata;
        VPC_VBI_START_ADDR: vbi_start_reg <= reg_wdata[7:0];
        VPC_VBI_END_ADDR: vbi_end_reg <= reg_wdata[7:0];
        VPC_VBI_LINES_ADDR: vbi_lines_reg <= reg_wdata[LINE_WIDTH-1:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Source bus released while software has the float bit set
  assign bus_float = ctrl_reg[VPC_CTRL_BUSOFF_BIT];

  wire [15:0] status_word = {12'h000, vbi_armed_reg, vbi_done_reg, state_reg == VPC_ST_LINE,
                             overflow_reg};
  wire [15:0] rdata_next = (reg_addr == VPC_CTRL_ADDR) ? ctrl_reg :
                           (reg_addr == VPC_VBI_START_ADDR) ? {8'h00, vbi_start_reg} :
                           (reg_addr == VPC_VBI_END_ADDR) ? {8'h00, vbi_end_reg} :
                           (reg_addr == VPC_VBI_LINES_ADDR) ? 16'(vbi_lines_reg) :
                           (reg_addr == VPC_STATUS_ADDR) ? status_word :
                           (reg_addr == VPC_COUNT_ADDR) ? count_reg : 16'h0000;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_read) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : vpc_capture

//--- inc/vpc_pkg.sv
// Purpose: Shared constants and types for the video port capture engine
// Assumes: 8-bit byte stream with embedded timing reference codes
// Notes: Register map and field layout live here
package vpc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] VPC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] VPC_VBI_START_ADDR = 4'h1;
  localparam logic [3:0] VPC_VBI_END_ADDR = 4'h2;
  localparam logic [3:0] VPC_VBI_LINES_ADDR = 4'h3;
  localparam logic [3:0] VPC_STATUS_ADDR = 4'h4;
  localparam logic [3:0] VPC_COUNT_ADDR = 4'h5;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int VPC_CTRL_EN_BIT = 0;
  localparam int VPC_CTRL_MODE_LSB = 1;
  localparam int VPC_CTRL_SCALE_LSB = 4;
  localparam int VPC_CTRL_BUSOFF_BIT = 9;
  localparam logic [15:0] VPC_CTRL_RESET = 16'h0010;

  // Blanking modes
  localparam logic [1:0] VPC_VBI_OFF = 2'h0;
  localparam logic [1:0] VPC_VBI_RAW = 2'h1;
  localparam logic [1:0] VPC_VBI_FRAMED = 2'h2;

  // Timing reference preamble and code bits
  localparam logic [7:0] VPC_PRE_FF = 8'hFF;
  localparam logic [7:0] VPC_PRE_00 = 8'h00;
  localparam int VPC_H_BIT = 4;
  localparam int VPC_V_BIT = 5;
  localparam int VPC_F_BIT = 6;
  localparam logic [4:0] VPC_SCALE_MIN = 5'h01;

  typedef enum logic [1:0] {
    VPC_PHASE_CB = 2'b00,
    VPC_PHASE_Y0 = 2'b01,
    VPC_PHASE_CR = 2'b11,
    VPC_PHASE_Y1 = 2'b10
  } vpc_phase_type;

  typedef enum logic [1:0] {
    VPC_ST_IDLE = 2'b00,
    VPC_ST_LINE = 2'b01,
    VPC_ST_VBI = 2'b11
  } vpc_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    vpc_phase_type phase;
  } vpc_pixel_type;

  // A code byte: F, V, H plus protection bits
  function automatic logic vpc_is_sav(input logic [7:0] code);
    return code[7] && !code[VPC_H_BIT];
  endfunction : vpc_is_sav

  function automatic logic vpc_is_eav(input logic [7:0] code);
    return code[7] && code[VPC_H_BIT];
  endfunction : vpc_is_eav

endpackage : vpc_pkg

//--- sim/vpc_capture_props.sv
// Purpose: Port-level checks of the capture engine
// Assumes: Sees only the top module ports
// Notes: Bound from the bench top file
`timescale 1ns/100ps
module vpc_capture_props
  import vpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] video_byte_bus,
  input wire logic fifo_ready,
  input wire vpc_pixel_type fifo_pixel,
  input wire logic active_video_flag,
  input wire logic bus_float,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic ctrl_wr = reg_write && reg_addr == VPC_CTRL_ADDR;
  wire logic v = fifo_pixel.valid;
  // ----
  // Checks
  // ----
  AST_FLAG_IS_VALID: assert property (active_video_flag == v)
    else $error("active flag differs from stored pulse");
  AST_BYTE_FROM_BUS: assert property (v |-> fifo_pixel.data == $past(video_byte_bus))
    else $error("stored byte not the bus byte");
  AST_CODE_DROPPED: assert property (($past(video_byte_bus, 3) == 8'hFF &&
    $past(video_byte_bus, 2) == 8'h00 && $past(video_byte_bus) == 8'h00) |=> !v)
    else $error("code byte stored");
  AST_PHASE_STEPS: assert property (v && $past(v) |->
    fifo_pixel.phase == {$past(fifo_pixel.phase[0]), ~$past(fifo_pixel.phase[1])})
    else $error("byte order broken");
  AST_OPEN_AT_CB: assert property ($rose(v) |-> fifo_pixel.phase == VPC_PHASE_CB)
    else $error("group does not start at Cb");
  AST_FLOAT_SET: assert property (ctrl_wr |=> bus_float == $past(reg_wdata[9]))
    else $error("release request not taken");
  AST_FLOAT_HELD: assert property (!$past(ctrl_wr) |-> $stable(bus_float))
    else $error("release request moved alone");
  AST_RDATA_QUIET: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  cover property ($rose(v));
  cover property ($rose(bus_float));
  cover property (reg_read ##1 reg_rdata != 16'h0000);
endmodule : vpc_capture_props

//--- sim/vpc_decoder_model.sv
// Purpose: Behavioural video decoder on the byte bus
// Assumes: One byte per clock, no handshake
// Notes: Released bus shows the inverse of the last byte
`timescale 1ns/100ps
module vpc_decoder_model (
  input wire logic clock,
  input wire logic bus_float,
  output logic [7:0] video_byte_bus
);
  logic [7:0] drv_reg = 8'h10;
  // Stale byte must not pass for live data
  assign video_byte_bus = bus_float ? ~drv_reg : drv_reg;
  task automatic put(input logic [7:0] b);
    @(posedge clock);
    drv_reg <= b;
  endtask : put
  task automatic code(input logic [7:0] xy);
    put(8'hFF);
    put(8'h00);
    put(8'h00);
    put(xy);
  endtask : code
  task automatic raw(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) put(base + 8'(i));
  endtask : raw
  task automatic line(input logic [7:0] sav, input logic [7:0] eav, input int n);
    code(sav);
    raw(n, 8'h20);
    code(eav);
  endtask : line
endmodule : vpc_decoder_model

//--- sim/test_video_port_capture_engine.sv
// Purpose: Self-checking bench for the capture engine
// Assumes: Decoder model drives the byte bus
// Notes: Stored bytes collected by a monitor queue
`timescale 1ns/100ps
module test_video_port_capture_engine;
  import vpc_pkg::*;
  logic clock = 0;
  logic reset_n = 0;
  logic fifo_ready = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 0;
  logic reg_read = 0;
  wire logic [7:0] video_byte_bus;
  vpc_pixel_type fifo_pixel;
  logic active_video_flag;
  logic bus_float;
  logic [15:0] reg_rdata;
  logic [15:0] got;
  logic [7:0] q[$];
  int mismatches = 0;
  int n_compared = 0;
  always #10 clock = ~clock;
  vpc_capture vpc_capture_inst (.clock(clock), .reset_n(reset_n),
    .video_byte_bus(video_byte_bus), .fifo_ready(fifo_ready), .fifo_pixel(fifo_pixel),
    .active_video_flag(active_video_flag), .bus_float(bus_float), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  vpc_decoder_model vpc_decoder_model_inst (.clock(clock), .bus_float(bus_float),
    .video_byte_bus(video_byte_bus));
  always @(posedge clock) begin
    if (fifo_pixel.valid === 1'b1) q.push_back(fifo_pixel.data);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_read <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 0;
    #1 got = reg_rdata;
  endtask : rd
  function automatic logic [15:0] ctl(input logic [1:0] m, input logic [4:0] s);
    return 16'h0001 | (16'(m) << 1) | (16'(s) << 4);
  endfunction : ctl
  task automatic lines(input logic [7:0] sav, input logic [7:0] eav, input int n, input int k);
    repeat (k) vpc_decoder_model_inst.line(sav, eav, n);
    repeat (2) @(posedge clock);
  endtask : lines
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ----
  // Scenarios
  // ----
  task automatic t_idle;
    rd(VPC_CTRL_ADDR);
    chk("ctrl reset", VPC_CTRL_RESET, got);
    rd(4'hF);
    chk("unmapped", 16'h0000, got);
    lines(8'h80, 8'h90, 4, 1);
    chk("disabled", 16'h0000, 16'(q.size()));
  endtask : t_idle
  task automatic t_normal;
    wr(VPC_CTRL_ADDR, ctl(VPC_VBI_OFF, 5'h01));
    q.delete();
    lines(8'h80, 8'h90, 8, 1);
    chk("line count", 16'h0008, 16'(q.size()));
    foreach (q[i]) chk("line byte", 16'(8'h20 + 8'(i)), 16'(q[i]));
  endtask : t_normal
  task automatic t_overflow;
    fifo_ready <= 1'b0;
    lines(8'h80, 8'h90, 4, 1);
    fifo_ready <= 1'b1;
    rd(VPC_STATUS_ADDR);
    chk("overflow set", 16'h0001, got);
    wr(VPC_STATUS_ADDR, 16'h0001);
    rd(VPC_STATUS_ADDR);
    chk("overflow cleared", 16'h0000, got);
  endtask : t_overflow
  task automatic t_scale(input logic [4:0] s);
    wr(VPC_CTRL_ADDR, ctl(VPC_VBI_OFF, s));
    q.delete();
    lines(8'h80, 8'h90, 4, 2 * int'(s));
    chk("decimated", 16'h0008, 16'(q.size()));
  endtask : t_scale
  task automatic t_raw;
    wr(VPC_VBI_LINES_ADDR, 16'h0001);
    wr(VPC_CTRL_ADDR, ctl(VPC_VBI_RAW, 5'h01));
    // New field loads the blanking region
    vpc_decoder_model_inst.code(8'hD0);
    q.delete();
    vpc_decoder_model_inst.line(8'hC0, 8'hF0, 4);
    vpc_decoder_model_inst.raw(6, 8'h40);
    lines(8'hC0, 8'hD0, 4, 1);
    chk("raw span", 16'h0011, 16'(q.size()));
    chk("raw head", 16'h0040, 16'(q[4]));
    chk("raw tail", 16'h0045, 16'(q[9]));
    rd(VPC_COUNT_ADDR);
    chk("raw bytes", 16'h0011, got);
  endtask : t_raw
  task automatic t_framed;
    wr(VPC_VBI_START_ADDR, 16'h00A0);
    wr(VPC_VBI_END_ADDR, 16'h00B0);
    wr(VPC_CTRL_ADDR, ctl(VPC_VBI_FRAMED, 5'h01));
    rd(VPC_VBI_START_ADDR);
    chk("start code", 16'h00A0, got);
    // New field rearms the blanking window
    vpc_decoder_model_inst.code(8'h90);
    q.delete();
    lines(8'hA0, 8'h90, 4, 1);
    lines(8'hA0, 8'h90, 6, 1);
    lines(8'hA0, 8'hB0, 2, 2);
    chk("framed count", 16'h000C, 16'(q.size()));
    rd(VPC_COUNT_ADDR);
    chk("framed bytes", 16'h000C, got);
  endtask : t_framed
  task automatic t_float;
    wr(VPC_CTRL_ADDR, 16'h0211);
    #1 chk("float on", 16'h0001, 16'(bus_float));
    wr(VPC_CTRL_ADDR, 16'h0011);
    #1 chk("float off", 16'h0000, 16'(bus_float));
  endtask : t_float
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1;
    t_idle();
    t_normal();
    t_overflow();
    t_scale(5'h02);
    t_scale(5'h1F);
    t_raw();
    t_framed();
    t_float();
    give_verdict();
  end
  // Run needs about 1000 cycles
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule : test_video_port_capture_engine
bind vpc_capture vpc_capture_props vpc_capture_props_inst (.clock(clock),
  .reset_n(reset_n), .video_byte_bus(video_byte_bus), .fifo_ready(fifo_ready),
  .fifo_pixel(fifo_pixel), .active_video_flag(active_video_flag), .bus_float(bus_float),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata));
